// File: mpc_pkg.sv
// Constants, register map and field positions of the monitor pin control block
package mpc_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_HZ = 20_000_000;
  localparam int RESET_PULSE_MS = 45;
  localparam int INTRUSION_PULSE_MS = 20;
  // Least times round up to whole cycles
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_MS * CLK_HZ + 999) / 1000;
  localparam int INTRUSION_PULSE_CYCLES = (INTRUSION_PULSE_MS * CLK_HZ + 999) / 1000;
  localparam int CNT_W = 20;

  // ==========================================================================
  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] CONFIG_OFFSET = 8'h40;
  localparam logic [7:0] STATUS_OFFSET = 8'h41;
  localparam logic [7:0] MASK_OFFSET = 8'h43;
  localparam logic [7:0] ID_LOW_OFFSET = 8'h47;
  localparam logic [7:0] ID_HIGH_OFFSET = 8'h49;
  localparam logic [7:0] ID_ROLE_OFFSET = 8'h4A;
  localparam logic [7:0] CHAN_CFG_OFFSET = 8'h4B;

  // ==========================================================================
  // Fields
  localparam int CFG_INT_EN_BIT = 1;
  localparam int CFG_RESET_PULSE_BIT = 4;
  localparam int CFG_INTRUSION_BIT = 6;
  localparam int ID_W = 5;
  localparam int ST_RESET_DONE_BIT = 5;
  localparam int ST_INTRUSION_DONE_BIT = 6;
  localparam int CHAN_DIODE_BIT = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [4:0] ID_ROLE_RESET = 5'h00;
  localparam logic [7:0] CHAN_CFG_RESET = 8'h00;

endpackage : mpc_pkg

// File: mpc_if.sv
// Interfaces joining the pin control top to its pulse timers and id capture
`timescale 1ns/100ps
interface mpc_pulse_if;
  logic start;
  logic busy;
  logic done;
  modport timer (input start, output busy, output done);
  modport ctrl (output start, input busy, input done);
endinterface : mpc_pulse_if

interface mpc_id_if;
  logic [4:0] role;
  logic [4:0] level;
  logic [4:0] irq_evt;
  modport capture (input role, output level, output irq_evt);
  modport ctrl (output role, input level, input irq_evt);
endinterface : mpc_id_if

// File: mpc_pulse_timer.sv
// Timed low pulse generator for an open-drain pin
`timescale 1ns/100ps
module mpc_pulse_timer #(
  parameter int CYCLES = 1
) (
  input wire logic clk,
  input wire logic reset,
  mpc_pulse_if.timer pulse
);
  import mpc_pkg::*;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic busy_q;
  logic done_q;
  logic [CNT_W-1:0] cnt_q;
  wire logic launch = pulse.start && !busy_q;
  wire logic at_end = busy_q && (cnt_q == '0);

  // ==========================================================================
  // Counter on the block clock, busy for exactly CYCLES cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      done_q <= at_end;
      if (launch) begin
        busy_q <= 1'b1;
        cnt_q <= LAST;
      end else if (at_end) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  assign pulse.busy = busy_q;
  assign pulse.done = done_q;
endmodule : mpc_pulse_timer

// File: mpc_id_capture.sv
// Sampling of the core id inputs and falling-edge events in interrupt role
`timescale 1ns/100ps
module mpc_id_capture (
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] pins,
  mpc_id_if.capture id
);
  import mpc_pkg::*;

  logic [ID_W-1:0] level_q;
  logic [ID_W-1:0] prev_q;
  logic [ID_W-1:0] evt_q;
  wire logic [ID_W-1:0] fall = prev_q & ~level_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      level_q <= '1;
      prev_q <= '1;
      evt_q <= '0;
    end else begin
      level_q <= pins;
      prev_q <= level_q;
      evt_q <= fall & id.role;
    end
  end

  assign id.level = level_q;
  assign id.irq_evt = evt_q;
endmodule : mpc_id_capture

// File: mpc_pin_ctrl.sv
// Pin control logic of the hardware monitor: interrupt, reset, test and id pins
`timescale 1ns/100ps
// Contract
// - The interrupt pin is driven only while config bit 1 is one, otherwise released.
// - Config bit 1 is cleared by reset so the interrupt pin starts disabled.
// - The interrupt pin is open drain, only ever pulled low.
// - Writing one to config bit 4 pulls the reset pin low through an open drain.
// - Each generated reset pulse lasts at least 45 ms before release.
// - An external low on the reset pin resets the block.
// - A high test-select pin places the device in connectivity test mode.
// - Without test mode the test-select pin serves as the analog output.
// - The five id inputs are sampled as digital levels.
// - Id inputs zero to three are readable in one status register.
// - Id input four is readable in a separate status register.
// - Each id input can be set to interrupt role, giving an interrupt source instead.
// - The second channel pins are selectable between voltage and diode mode.
// - Config bit 6 drives the intrusion line low for at least 20 ms.
module mpc_pin_ctrl #(
  parameter int RESET_PULSE_LEN = mpc_pkg::RESET_PULSE_CYCLES,
  parameter int INTRUSION_PULSE_LEN = mpc_pkg::INTRUSION_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [mpc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mpc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [mpc_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  output logic int_pin_out,
  output logic int_pin_oe_n,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  input wire logic chassis_intrusion_line_in,
  output logic chassis_intrusion_line_out,
  output logic chassis_intrusion_line_oe_n,
  input wire logic test_select_or_analog_out,
  output logic test_mode,
  output logic analog_out_en,
  input wire logic core_id_bit0_or_irq_in,
  input wire logic core_id_bit1_or_irq_in,
  input wire logic core_id_bit2_or_irq_in,
  input wire logic core_id_bit3_or_irq_in,
  input wire logic core_id_bit4_or_irq_in,
  output logic second_channel_diode_mode
);
  import mpc_pkg::*;

  // ==========================================================================
  // State
  logic [7:0] config_q;
  logic [7:0] status_q;
  logic [7:0] mask_q;
  logic [ID_W-1:0] id_role_q;
  logic [7:0] chan_cfg_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic int_oe_n_q;
  logic reset_oe_n_q;
  logic intrusion_oe_n_q;
  logic test_mode_q;
  logic analog_en_q;
  logic diode_q;
  logic intrusion_seen_q;

  mpc_pulse_if reset_pulse ();
  mpc_pulse_if intrusion_pulse ();
  mpc_id_if id ();

  // ==========================================================================
  // Block reset: port reset or a low on the reset pin not caused by ourselves
  wire logic ext_reset_req = !reset_pin_in && reset_oe_n_q;
  wire logic rst = reset || ext_reset_req;

  // ==========================================================================
  // Address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  wire logic wr_config = reg_we && hit(reg_addr, CONFIG_OFFSET);
  wire logic wr_status = reg_we && hit(reg_addr, STATUS_OFFSET);
  wire logic wr_mask = reg_we && hit(reg_addr, MASK_OFFSET);
  wire logic wr_role = reg_we && hit(reg_addr, ID_ROLE_OFFSET);
  wire logic wr_chan = reg_we && hit(reg_addr, CHAN_CFG_OFFSET);

  // Pulse requests launch on a written one; a request during a pulse is ignored
  assign reset_pulse.start = wr_config && reg_wdata[CFG_RESET_PULSE_BIT];
  assign intrusion_pulse.start = wr_config && reg_wdata[CFG_INTRUSION_BIT];

  // ==========================================================================
  // Sub-blocks
  mpc_pulse_timer #(
    .CYCLES(RESET_PULSE_LEN)
  ) u_reset_timer (
    .clk(clk),
    .reset(rst),
    .pulse(reset_pulse)
  );

  mpc_pulse_timer #(
    .CYCLES(INTRUSION_PULSE_LEN)
  ) u_intrusion_timer (
    .clk(clk),
    .reset(rst),
    .pulse(intrusion_pulse)
  );

  mpc_id_capture u_id_capture (
    .clk(clk),
    .reset(rst),
    .pins({core_id_bit4_or_irq_in, core_id_bit3_or_irq_in, core_id_bit2_or_irq_in,
           core_id_bit1_or_irq_in, core_id_bit0_or_irq_in}),
    .id(id)
  );

  assign id.role = id_role_q;

  // ==========================================================================
  // Interrupt sources: id pins in interrupt role, end of each pulse
  wire logic [7:0] events = {1'b0, intrusion_pulse.done, reset_pulse.done, id.irq_evt};
  wire logic [7:0] status_clr = wr_status ? reg_wdata : 8'h00;
  // Set wins over a clear in the same cycle
  wire logic [7:0] status_d = (status_q & ~status_clr) | events;
  wire logic pending = |(status_d & mask_q);
  wire logic int_enable = config_q[CFG_INT_EN_BIT];

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      config_q <= CONFIG_RESET;
      status_q <= STATUS_RESET;
      mask_q <= MASK_RESET;
      id_role_q <= ID_ROLE_RESET;
      chan_cfg_q <= CHAN_CFG_RESET;
    end else begin
      status_q <= status_d;
      if (wr_config) begin
        config_q <= reg_wdata & ~(8'h01 << CFG_RESET_PULSE_BIT) & ~(8'h01 << CFG_INTRUSION_BIT);
      end
      if (wr_mask) begin
        mask_q <= reg_wdata;
      end
      if (wr_role) begin
        id_role_q <= reg_wdata[ID_W-1:0];
      end
      if (wr_chan) begin
        chan_cfg_q <= reg_wdata;
      end
    end
  end

  // ==========================================================================
  // Read path, data in the cycle after the strobe
  wire logic [7:0] config_view = config_q
    | ({7'h00, reset_pulse.busy} << CFG_RESET_PULSE_BIT)
    | ({7'h00, intrusion_pulse.busy} << CFG_INTRUSION_BIT);
  wire logic [4:0] id_val = id.level & ~id_role_q;
  wire logic [7:0] id_low_view = {4'h0, id_val[3:0]};
  wire logic [7:0] id_high_view = {7'h00, id_val[4]};
  wire logic [7:0] chan_view = chan_cfg_q;
  wire logic [7:0] role_view = {3'h0, id_role_q};

  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      CONFIG_OFFSET: rd_mux = config_view;
      STATUS_OFFSET: rd_mux = status_q;
      MASK_OFFSET: rd_mux = mask_q;
      ID_LOW_OFFSET: rd_mux = id_low_view;
      ID_HIGH_OFFSET: rd_mux = id_high_view;
      ID_ROLE_OFFSET: rd_mux = role_view;
      CHAN_CFG_OFFSET: rd_mux = chan_view;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_re ? rd_mux : 8'h00;
    end
  end

  // ==========================================================================
  // Pin drivers, all open drain with active low enables
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
      int_oe_n_q <= 1'b1;
      reset_oe_n_q <= 1'b1;
      intrusion_oe_n_q <= 1'b1;
    end else begin
      irq_q <= pending;
      int_oe_n_q <= !(int_enable && pending);
      reset_oe_n_q <= !reset_pulse.busy;
      intrusion_oe_n_q <= !intrusion_pulse.busy;
    end
  end

  // ==========================================================================
  // Test select, analog output and second channel mode
  always_ff @(posedge clk) begin
    if (rst) begin
      test_mode_q <= 1'b0;
      analog_en_q <= 1'b0;
      diode_q <= 1'b0;
      intrusion_seen_q <= 1'b0;
    end else begin
      test_mode_q <= test_select_or_analog_out;
      analog_en_q <= !test_select_or_analog_out;
      diode_q <= chan_cfg_q[CHAN_DIODE_BIT];
      intrusion_seen_q <= chassis_intrusion_line_in;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign int_pin_out = 1'b0;
  assign int_pin_oe_n = int_oe_n_q;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe_n = reset_oe_n_q;
  assign chassis_intrusion_line_out = 1'b0;
  assign chassis_intrusion_line_oe_n = intrusion_oe_n_q;
  assign test_mode = test_mode_q;
  assign analog_out_en = analog_en_q;
  assign second_channel_diode_mode = diode_q;

endmodule : mpc_pin_ctrl

// File: mpc_board_model.sv
// Board side of the pin control block: pulled-up pins and reset source
`timescale 1ns/100ps
module mpc_board_model (
  input wire logic ext_req,
  input wire logic int_oe_n,
  input wire logic rst_oe_n,
  input wire logic ci_oe_n,
  output logic int_lvl,
  output logic rst_lvl,
  output logic ci_lvl
);
  // Released lines float up to the pull-up level
  assign int_lvl = int_oe_n;
  assign rst_lvl = rst_oe_n & ~ext_req;
  assign ci_lvl = ci_oe_n;
endmodule : mpc_board_model

// File: mpc_pin_ctrl_properties.sv
// Concurrent checks on the pin control top ports
`timescale 1ns/100ps
module mpc_pin_ctrl_properties #(
  parameter int RESET_PULSE_LEN = 20,
  parameter int INTRUSION_PULSE_LEN = 10
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [mpc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mpc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic irq,
  input wire logic int_pin_out,
  input wire logic int_pin_oe_n,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic chassis_intrusion_line_out,
  input wire logic chassis_intrusion_line_oe_n,
  input wire logic test_select_or_analog_out,
  input wire logic test_mode,
  input wire logic analog_out_en
);
  import mpc_pkg::*;
  logic blk_rst;
  logic [CNT_W-1:0] rst_cnt_q;
  logic [CNT_W-1:0] ci_cnt_q;
  // An external low on the reset pin resets the block like the reset input
  assign blk_rst = reset | (~reset_pin_in & reset_pin_oe_n);
  always_ff @(posedge clk) begin
    rst_cnt_q <= (blk_rst | reset_pin_oe_n) ? '0 : rst_cnt_q + 1'b1;
    ci_cnt_q <= (blk_rst | chassis_intrusion_line_oe_n) ? '0 : ci_cnt_q + 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (blk_rst);
  // =====
  // Assertions
  open_drain_low_a: assert property (
    !int_pin_out && !reset_pin_out && !chassis_intrusion_line_out)
    else $error("open drain data not low");
  int_pin_gate_a: assert property (!int_pin_oe_n |-> irq)
    else $error("interrupt pin low without pending source");
  rst_pulse_start_a: assert property ($fell(reset_pin_oe_n) |->
    $past(reg_we, 2) && $past(reg_addr, 2) == CONFIG_OFFSET
    && $past(reg_wdata[CFG_RESET_PULSE_BIT], 2))
    else $error("reset pulse without config write");
  ci_pulse_start_a: assert property ($fell(chassis_intrusion_line_oe_n) |->
    $past(reg_we, 2) && $past(reg_addr, 2) == CONFIG_OFFSET
    && $past(reg_wdata[CFG_INTRUSION_BIT], 2))
    else $error("intrusion pulse without config write");
  rst_pulse_width_a: assert property (
    $rose(reset_pin_oe_n) |-> rst_cnt_q == RESET_PULSE_LEN)
    else $error("reset pulse width wrong");
  ci_pulse_width_a: assert property (
    $rose(chassis_intrusion_line_oe_n) |-> ci_cnt_q == INTRUSION_PULSE_LEN)
    else $error("intrusion pulse width wrong");
  test_mode_track_a: assert property (
    !$past(blk_rst) |-> test_mode == $past(test_select_or_analog_out))
    else $error("test mode does not follow pin");
  analog_out_inv_a: assert property (
    !$past(blk_rst) |-> analog_out_en == !test_mode)
    else $error("analog output enable not inverse of test mode");
  cover property ($fell(reset_pin_oe_n));
  cover property ($fell(chassis_intrusion_line_oe_n));
  cover property ($fell(int_pin_oe_n));
  cover property ($rose(test_mode));
endmodule : mpc_pin_ctrl_properties

bind mpc_pin_ctrl mpc_pin_ctrl_properties #(
  .RESET_PULSE_LEN(RESET_PULSE_LEN),
  .INTRUSION_PULSE_LEN(INTRUSION_PULSE_LEN)
) chk_u (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .irq(irq), .int_pin_out(int_pin_out), .int_pin_oe_n(int_pin_oe_n),
  .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
  .reset_pin_oe_n(reset_pin_oe_n), .chassis_intrusion_line_out(chassis_intrusion_line_out),
  .chassis_intrusion_line_oe_n(chassis_intrusion_line_oe_n),
  .test_select_or_analog_out(test_select_or_analog_out),
  .test_mode(test_mode), .analog_out_en(analog_out_en)
);

// File: mpc_pin_ctrl_tb_top.sv
// Self-checking bench of the pin control block
`timescale 1ns/100ps
module mpc_pin_ctrl_tb_top;
  import mpc_pkg::*;
  typedef struct packed {logic [4:0] pins; logic [7:0] lo; logic [7:0] hi;} mpc_row_s;
  mpc_row_s rows [4] = '{'{5'h00, 8'h00, 8'h00}, '{5'h1F, 8'h0F, 8'h01},
    '{5'h0A, 8'h0A, 8'h00}, '{5'h15, 8'h05, 8'h01}};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [4:0] id_pins = 5'h1F;
  logic test_sel = 1'b0;
  logic ext_req = 1'b0;
  logic [7:0] rdata;
  logic irq, int_out, int_oe_n, rst_out, rst_oe_n, ci_out, ci_oe_n;
  logic tmode, aen, diode, int_lvl, rst_lvl, ci_lvl;
  int miscompares = 0;
  int total_checks = 0;
  initial forever #25 clk = ~clk;
  mpc_pin_ctrl #(.RESET_PULSE_LEN(20), .INTRUSION_PULSE_LEN(10)) dut_u (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(rdata), .irq(irq),
    .int_pin_out(int_out), .int_pin_oe_n(int_oe_n), .reset_pin_in(rst_lvl),
    .reset_pin_out(rst_out), .reset_pin_oe_n(rst_oe_n),
    .chassis_intrusion_line_in(ci_lvl), .chassis_intrusion_line_out(ci_out),
    .chassis_intrusion_line_oe_n(ci_oe_n), .test_select_or_analog_out(test_sel),
    .test_mode(tmode), .analog_out_en(aen), .core_id_bit0_or_irq_in(id_pins[0]),
    .core_id_bit1_or_irq_in(id_pins[1]), .core_id_bit2_or_irq_in(id_pins[2]),
    .core_id_bit3_or_irq_in(id_pins[3]), .core_id_bit4_or_irq_in(id_pins[4]),
    .second_channel_diode_mode(diode));
  mpc_board_model board_u (.ext_req(ext_req), .int_oe_n(int_oe_n), .rst_oe_n(rst_oe_n),
    .ci_oe_n(ci_oe_n), .int_lvl(int_lvl), .rst_lvl(rst_lvl), .ci_lvl(ci_lvl));
  // =====
  // Tasks
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rc(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    chk(name, rdata, exp);
  endtask : rc
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  // Waits for the pulse to start, then counts its low cycles
  task automatic pulse(input bit ci, input int n);
    int w;
    int i;
    w = 0;
    i = 0;
    while ((ci ? ci_oe_n : rst_oe_n) !== 1'b0 && w < 8) begin
      @(negedge clk);
      w++;
    end
    if (w == 8) begin
      chk("pulse start", 8'h00, 8'h01);
      results();
    end
    while ((ci ? ci_oe_n : rst_oe_n) === 1'b0 && i < 200) begin
      @(negedge clk);
      i++;
    end
    chk("pulse width", 8'(i), 8'(n));
  endtask : pulse
  // =====
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rc("config", CONFIG_OFFSET, CONFIG_RESET);
    chk("int pin", {7'h00, int_lvl}, 8'h01);
    chk("analog", {6'h00, tmode, aen}, 8'h01);
    rc("unmapped", 8'h50, 8'h00);
    $display("test reset done");
    foreach (rows[k]) begin
      @(posedge clk);
      id_pins <= rows[k].pins;
      repeat (4) @(posedge clk);
      rc("id low", ID_LOW_OFFSET, rows[k].lo);
      rc("id high", ID_HIGH_OFFSET, rows[k].hi);
    end
    $display("test id table done");
    wr(MASK_OFFSET, 8'h21);
    wr(ID_ROLE_OFFSET, 8'h01);
    repeat (4) @(posedge clk);
    id_pins <= 5'h1E;
    repeat (5) @(posedge clk);
    rc("id event", STATUS_OFFSET, 8'h01);
    rc("id role", ID_LOW_OFFSET, 8'h0E);
    chk("irq", {7'h00, irq}, 8'h01);
    chk("int off", {7'h00, int_lvl}, 8'h01);
    wr(CONFIG_OFFSET, 8'h02);
    repeat (2) @(negedge clk);
    chk("int on", {7'h00, int_lvl}, 8'h00);
    wr(MASK_OFFSET, 8'h20);
    repeat (2) @(negedge clk);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(STATUS_OFFSET, 8'h01);
    rc("status clr", STATUS_OFFSET, 8'h00);
    $display("test interrupt done");
    wr(CONFIG_OFFSET, 8'h12);
    rc("busy", CONFIG_OFFSET, 8'h12);
    pulse(1'b0, 20);
    rc("done", STATUS_OFFSET, 8'h20);
    repeat (2) @(negedge clk);
    chk("int done", {7'h00, int_lvl}, 8'h00);
    wr(STATUS_OFFSET, 8'h20);
    wr(CONFIG_OFFSET, 8'h40);
    pulse(1'b1, 10);
    $display("test pulses done");
    wr(CHAN_CFG_OFFSET, 8'h01);
    test_sel <= 1'b1;
    repeat (2) @(negedge clk);
    chk("test", {6'h00, tmode, aen}, 8'h02);
    chk("diode", {7'h00, diode}, 8'h01);
    wr(CONFIG_OFFSET, 8'h02);
    ext_req <= 1'b1;
    repeat (2) @(posedge clk);
    ext_req <= 1'b0;
    rc("ext reset", CONFIG_OFFSET, CONFIG_RESET);
    $display("test pins done");
    results();
  end
endmodule : mpc_pin_ctrl_tb_top
